// ### hdl/cocfg_pkg.sv
// package for the code option configuration block: option layout, timing and register map
package cocfg_pkg;
  // register indices on the plain register port (word addressed)
  localparam logic [3:0] ADDR_OPTIONS   = 4'h0;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h1;
  localparam logic [3:0] ADDR_IRQ_REQ   = 4'h2;
  localparam logic [3:0] ADDR_IE_A      = 4'h3;
  localparam logic [3:0] ADDR_IE_B      = 4'h4;
  localparam logic [3:0] ADDR_CLKMODE   = 4'h5;
  localparam logic [3:0] ADDR_TA_CTRL   = 4'h6;
  localparam logic [3:0] ADDR_TB_CTRL   = 4'h7;
  localparam logic [3:0] ADDR_TA_SCALE  = 4'h8;
  localparam logic [3:0] ADDR_TB_SCALE  = 4'h9;
  localparam logic [3:0] ADDR_GIE       = 4'hA;
  localparam logic [3:0] ADDR_STATUS    = 4'hB;
  localparam logic [3:0] ADDR_PROG      = 4'hC;
  // irq request bit positions
  localparam int IRQ_EXT0 = 0;
  localparam int IRQ_EXT1 = 1;
  localparam int IRQ_CMP  = 2;
  localparam int IRQ_W    = 3;
  // option word field positions
  localparam int OPT_SECURE   = 0;
  localparam int OPT_BOOTFAST = 1;
  localparam int OPT_SRC0_PB5 = 2;
  localparam int OPT_SRC1_PA4 = 3;
  localparam int OPT_EDGE_LO  = 4;
  localparam int OPT_GATE     = 6;
  localparam int OPT_CLK32    = 7;
  localparam int OPT_RES7     = 8;
  localparam int OPT_OUT_PB0  = 9;
  localparam int OPT_W        = 10;
  // comparator edge option encoding
  localparam logic [1:0] EDGE_ALL  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  // timer fields
  localparam logic [3:0] TCLK_FAST = 4'h2;
  localparam logic [1:0] TOUT_SEL  = 2'h1;
  localparam int SCALE_PWM_BIT = 7;
  localparam int CLKMODE_RST_BIT = 0;
  // boot delay in slow oscillator cycles
  localparam int BOOT_SLOW_CYC = 3000;
  localparam int BOOT_FAST_CYC = 45;
  localparam logic [11:0] BOOT_SLOW_CNT = 12'(BOOT_SLOW_CYC);
  localparam logic [11:0] BOOT_FAST_CNT = 12'(BOOT_FAST_CYC);
  localparam logic [7:0] READ_BLOCKED = 8'h00;

  typedef struct packed {
    logic [2:0] s;
    logic       prev;
  } cocfg_sync_s;

  typedef struct packed {
    logic [OPT_W-1:0] opt;
    logic             booted;
    logic [11:0]      boot_cnt;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] irq_req;
    logic             gie;
    logic [7:0]       ie_a;
    logic [7:0]       ie_b;
    logic [7:0]       clkmode;
    logic [7:0]       ta_ctrl;
    logic [7:0]       tb_ctrl;
    logic [7:0]       ta_scale;
    logic [7:0]       tb_scale;
    logic [7:0]       rdata;
    logic             irq;
    logic             wake;
    logic             pa5_oe;
    logic             ext_rst_n;
    logic             pwm_en;
    logic             pb2_out;
    logic             pb0_out;
    logic [1:0]       ta_res;
    logic [1:0]       tb_res;
    logic             ta_fast;
    logic             tb_fast;
    logic             ta_x2;
    logic             tb_x2;
  } cocfg_state_s;
endpackage

// ### hdl/cocfg_top.sv
// code option configuration: boot delay, option steering, interrupt gating, pin rules
// Functional notes
// RQ1: secure option set blocks program readback; clear lets it through.
// RQ2: hold off execution 3000 or 45 slow oscillator cycles after reset.
// RQ3: interrupt bit 0 comes from port_a_pin0 or port_b_pin5 per option.
// RQ4: interrupt bit 1 comes from port_b_pin0 or port_a_pin4 per option.
// RQ5: comparator interrupt on both, rising, or falling edges per option.
// RQ6: gating option lets comparator output decide whether pwm output drives.
// RQ7: timer clock select 0010 picks fast oscillator, optionally doubled.
// RQ8: scale bit 7 set gives 6 or 7 bit pwm resolution per option.
// RQ9: timer a output select 1 routes output to pin b2 or b0.
// RQ10: software enables bits, clears requests, then global enable.
// RQ11: enable and request registers get no defined reset value.
// RQ12: global disable blocks every interrupt until enabled again.
// RQ13: an input pin wakes only when its input enable bit is one.
// RQ14: port_a_pin5 is open drain only, never drives high.
// RQ15: clock mode bit 0 with pin5 input makes it external reset.
// RQ16: options load from program memory before boot, then stay constant.
module cocfg_top (
  input  wire logic                        core_clk_i,     // system clock 40 MHz
  input  wire logic                        rst_n_i,        // sync reset, active low
  input  wire logic                        slow_osc_i,     // slow_internal_osc level
  input  wire logic [cocfg_pkg::OPT_W-1:0] opt_word_i,     // option word from program memory
  input  wire logic [3:0]                  addr_i,         // register index
  input  wire logic [7:0]                  wdata_i,        // write data
  input  wire logic                        wr_i,           // write strobe
  input  wire logic                        rd_i,           // read strobe
  input  wire logic [7:0]                  prog_data_i,    // program memory byte for readback
  input  wire logic                        port_a_pin0_i,  // pin level
  input  wire logic                        port_a_pin4_i,  // pin level
  input  wire logic                        port_a_pin5_i,  // pin level
  input  wire logic                        port_b_pin0_i,  // pin level
  input  wire logic                        port_b_pin5_i,  // pin level
  input  wire logic                        cmp_out_i,      // general_comparator output
  input  wire logic                        pa5_is_input_i, // port_a_pin5 direction is input
  input  wire logic                        pa5_drive_lo_i, // port logic wants pin5 low
  input  wire logic                        pwm_a_i,        // pwm_timer_a raw output
  output logic      [7:0]                  rdata_o,        // read data, cycle after read
  output logic                             booted_o,       // execution may start
  output logic                             irq_o,          // interrupt to core, level
  output logic                             wake_o,         // pin wake request
  output logic                             pa5_o,          // pin5 output value, always 0
  output logic                             pa5_oe_o,       // pin5 drive enable
  output logic                             ext_reset_n_o,  // external reset, active low
  output logic                             pwm_en_o,       // pwm output drive enable
  output logic                             pb2_o,          // timer a on pin b2
  output logic                             pb0_o,          // timer a on pin b0
  output logic      [1:0]                  ta_res_o,       // 0 full, 1 six, 2 seven bit
  output logic      [1:0]                  tb_res_o,       // 0 full, 1 six, 2 seven bit
  output logic                             ta_fast_o,      // timer a on fast_internal_osc
  output logic                             tb_fast_o,      // timer b on fast_internal_osc
  output logic                             ta_x2_o,        // timer a at doubled rate
  output logic                             tb_x2_o         // timer b at doubled rate
);

  // synchronisers for pins, comparator and slow oscillator; first stage only feeds the second
  localparam int NS = 7;
  logic [NS-1:0] raw;
  logic [NS-1:0] clean;
  logic [NS-1:0] rose;
  logic [NS-1:0] fell;
  cocfg_pkg::cocfg_sync_s sync_q [NS];
  assign raw = {slow_osc_i, port_a_pin0_i, port_a_pin4_i, port_a_pin5_i,
                port_b_pin0_i, port_b_pin5_i, cmp_out_i};

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      // change counts once stages two and three agree
      always_ff @(posedge core_clk_i) begin
        sync_q[g].s    <= {sync_q[g].s[1:0], raw[g]};
        if (sync_q[g].s[2] == sync_q[g].s[1]) begin
          sync_q[g].prev <= sync_q[g].s[2];
        end
      end
      assign clean[g] = sync_q[g].prev;
      assign rose[g]  = (sync_q[g].s[2] == sync_q[g].s[1]) && sync_q[g].s[2] && !sync_q[g].prev;
      assign fell[g]  = (sync_q[g].s[2] == sync_q[g].s[1]) && !sync_q[g].s[2] && sync_q[g].prev;
    end
  endgenerate

  // index names for the sync vector
  localparam int S_CMP = 0;
  localparam int S_B5  = 1;
  localparam int S_B0  = 2;
  localparam int S_A5  = 3;
  localparam int S_A4  = 4;
  localparam int S_A0  = 5;
  localparam int S_OSC = 6;

  // timer steering shared by both timers
  function automatic logic [1:0] res_of(input logic [7:0] scale, input logic res7);
    if (!scale[cocfg_pkg::SCALE_PWM_BIT]) begin
      res_of = 2'h0;
    end else if (res7) begin
      res_of = 2'h2;
    end else begin
      res_of = 2'h1;
    end
  endfunction

  cocfg_pkg::cocfg_state_s st;
  cocfg_pkg::cocfg_state_s next_st;
  logic [cocfg_pkg::IRQ_W-1:0] ev;
  logic                        cmp_ev;
  logic [1:0]                  edge_sel;
  logic [11:0]                 boot_lim;

  always_comb begin
    next_st  = st;
    edge_sel = st.opt[cocfg_pkg::OPT_EDGE_LO +: 2];
    // comparator edge choice
    case (edge_sel)
      cocfg_pkg::EDGE_RISE: cmp_ev = rose[S_CMP]; // RQ5
      cocfg_pkg::EDGE_FALL: cmp_ev = fell[S_CMP]; // RQ5
      default:              cmp_ev = rose[S_CMP] | fell[S_CMP]; // RQ5
    endcase
    // external sources picked by options, taken on a rising edge
    ev[cocfg_pkg::IRQ_EXT0] = st.opt[cocfg_pkg::OPT_SRC0_PB5] ? rose[S_B5] : rose[S_A0]; // RQ3
    ev[cocfg_pkg::IRQ_EXT1] = st.opt[cocfg_pkg::OPT_SRC1_PA4] ? rose[S_A4] : rose[S_B0]; // RQ4
    ev[cocfg_pkg::IRQ_CMP]  = cmp_ev;
    boot_lim = st.opt[cocfg_pkg::OPT_BOOTFAST] ? cocfg_pkg::BOOT_FAST_CNT
                                               : cocfg_pkg::BOOT_SLOW_CNT;

    // boot delay counts slow oscillator rising edges
    if (!st.booted) begin
      next_st.opt = opt_word_i; // RQ16
      if (rose[S_OSC]) begin
        next_st.boot_cnt = st.boot_cnt + 12'h001;
      end
      if (st.boot_cnt >= boot_lim) begin
        next_st.booted = 1'b1; // RQ2
      end
    end

    // register writes; the option word has no write path
    if (wr_i && st.booted) begin
      if (addr_i == cocfg_pkg::ADDR_IRQ_EN) begin
        next_st.irq_en = wdata_i[cocfg_pkg::IRQ_W-1:0];
      end else if (addr_i == cocfg_pkg::ADDR_IRQ_REQ) begin
        next_st.irq_req = st.irq_req & ~wdata_i[cocfg_pkg::IRQ_W-1:0];
      end else if (addr_i == cocfg_pkg::ADDR_IE_A) begin
        next_st.ie_a = wdata_i;
      end else if (addr_i == cocfg_pkg::ADDR_IE_B) begin
        next_st.ie_b = wdata_i;
      end else if (addr_i == cocfg_pkg::ADDR_CLKMODE) begin
        next_st.clkmode = wdata_i;
      end else if (addr_i == cocfg_pkg::ADDR_TA_CTRL) begin
        next_st.ta_ctrl = wdata_i;
      end else if (addr_i == cocfg_pkg::ADDR_TB_CTRL) begin
        next_st.tb_ctrl = wdata_i;
      end else if (addr_i == cocfg_pkg::ADDR_TA_SCALE) begin
        next_st.ta_scale = wdata_i;
      end else if (addr_i == cocfg_pkg::ADDR_TB_SCALE) begin
        next_st.tb_scale = wdata_i;
      end else if (addr_i == cocfg_pkg::ADDR_GIE) begin
        next_st.gie = wdata_i[0]; // RQ12
      end
    end
    // requests are sticky; a new event beats a same-cycle clear
    next_st.irq_req = next_st.irq_req | (st.booted ? ev : '0);

    // reads answer next cycle; unmapped reads give zero
    next_st.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == cocfg_pkg::ADDR_OPTIONS) begin
        next_st.rdata = st.opt[7:0];
      end else if (addr_i == cocfg_pkg::ADDR_IRQ_EN) begin
        next_st.rdata = {5'h00, st.irq_en};
      end else if (addr_i == cocfg_pkg::ADDR_IRQ_REQ) begin
        next_st.rdata = {5'h00, st.irq_req};
      end else if (addr_i == cocfg_pkg::ADDR_IE_A) begin
        next_st.rdata = st.ie_a;
      end else if (addr_i == cocfg_pkg::ADDR_IE_B) begin
        next_st.rdata = st.ie_b;
      end else if (addr_i == cocfg_pkg::ADDR_CLKMODE) begin
        next_st.rdata = st.clkmode;
      end else if (addr_i == cocfg_pkg::ADDR_TA_CTRL) begin
        next_st.rdata = st.ta_ctrl;
      end else if (addr_i == cocfg_pkg::ADDR_TB_CTRL) begin
        next_st.rdata = st.tb_ctrl;
      end else if (addr_i == cocfg_pkg::ADDR_TA_SCALE) begin
        next_st.rdata = st.ta_scale;
      end else if (addr_i == cocfg_pkg::ADDR_TB_SCALE) begin
        next_st.rdata = st.tb_scale;
      end else if (addr_i == cocfg_pkg::ADDR_GIE) begin
        next_st.rdata = {7'h00, st.gie};
      end else if (addr_i == cocfg_pkg::ADDR_STATUS) begin
        next_st.rdata = {6'h00, st.opt[cocfg_pkg::OPT_SECURE], st.booted};
      end else if (addr_i == cocfg_pkg::ADDR_PROG) begin
        next_st.rdata = st.opt[cocfg_pkg::OPT_SECURE] ? cocfg_pkg::READ_BLOCKED
                                                      : prog_data_i; // RQ1
      end
    end

    // interrupt reaches the core only under global enable
    next_st.irq = st.gie && |(next_st.irq_req & st.irq_en); // RQ12

    // wake from port a pins 0 and 4 and port b pins 0 and 5 only with input enable set
    next_st.wake = (rose[S_A0] && st.ie_a[0]) || (rose[S_A4] && st.ie_a[4]) ||
                   (rose[S_B0] && st.ie_b[0]) || (rose[S_B5] && st.ie_b[5]); // RQ13

    // pin5 only pulls low, never drives high
    next_st.pa5_oe    = !pa5_is_input_i && pa5_drive_lo_i; // RQ14
    next_st.ext_rst_n = !(pa5_is_input_i && st.clkmode[cocfg_pkg::CLKMODE_RST_BIT]
                          && !clean[S_A5]); // RQ15

    // comparator gating of the pwm output
    next_st.pwm_en = st.opt[cocfg_pkg::OPT_GATE] ? clean[S_CMP] : 1'b1; // RQ6
    next_st.pb2_out = (st.ta_ctrl[3:2] == cocfg_pkg::TOUT_SEL) && next_st.pwm_en
                      && !st.opt[cocfg_pkg::OPT_OUT_PB0] && pwm_a_i; // RQ9
    next_st.pb0_out = (st.ta_ctrl[3:2] == cocfg_pkg::TOUT_SEL) && next_st.pwm_en
                      && st.opt[cocfg_pkg::OPT_OUT_PB0] && pwm_a_i; // RQ9

    // timer clock source and resolution
    next_st.ta_fast = st.ta_ctrl[7:4] == cocfg_pkg::TCLK_FAST; // RQ7
    next_st.tb_fast = st.tb_ctrl[7:4] == cocfg_pkg::TCLK_FAST; // RQ7
    next_st.ta_x2   = next_st.ta_fast && st.opt[cocfg_pkg::OPT_CLK32]; // RQ7
    next_st.tb_x2   = next_st.tb_fast && st.opt[cocfg_pkg::OPT_CLK32]; // RQ7
    next_st.ta_res  = res_of(st.ta_scale, st.opt[cocfg_pkg::OPT_RES7]); // RQ8
    next_st.tb_res  = res_of(st.tb_scale, st.opt[cocfg_pkg::OPT_RES7]); // RQ8
  end

  // irq_en and irq_req are left out of reset on purpose
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st.opt       <= '0;
      st.booted    <= 1'b0;
      st.boot_cnt  <= 12'h000;
      st.gie       <= 1'b0;
      st.ie_a      <= 8'h00;
      st.ie_b      <= 8'h00;
      st.clkmode   <= 8'h00;
      st.ta_ctrl   <= 8'h00;
      st.tb_ctrl   <= 8'h00;
      st.ta_scale  <= 8'h00;
      st.tb_scale  <= 8'h00;
      st.rdata     <= 8'h00;
      st.irq       <= 1'b0;
      st.wake      <= 1'b0;
      st.pa5_oe    <= 1'b0;
      st.ext_rst_n <= 1'b1;
      st.pwm_en    <= 1'b0;
      st.pb2_out   <= 1'b0;
      st.pb0_out   <= 1'b0;
      st.ta_res    <= 2'h0;
      st.tb_res    <= 2'h0;
      st.ta_fast   <= 1'b0;
      st.tb_fast   <= 1'b0;
      st.ta_x2     <= 1'b0;
      st.tb_x2     <= 1'b0;
      st.irq_en    <= next_st.irq_en; // RQ11
      st.irq_req   <= next_st.irq_req; // RQ11
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o       = st.rdata;
  assign booted_o      = st.booted;
  assign irq_o         = st.irq;
  assign wake_o        = st.wake;
  assign pa5_o         = 1'b0; // RQ14
  assign pa5_oe_o      = st.pa5_oe;
  assign ext_reset_n_o = st.ext_rst_n;
  assign pwm_en_o      = st.pwm_en;
  assign pb2_o         = st.pb2_out;
  assign pb0_o         = st.pb0_out;
  assign ta_res_o      = st.ta_res;
  assign tb_res_o      = st.tb_res;
  assign ta_fast_o     = st.ta_fast;
  assign tb_fast_o     = st.tb_fast;
  assign ta_x2_o       = st.ta_x2;
  assign tb_x2_o       = st.tb_x2;

  // assertions
  property p_irq_needs_gie;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !st.gie |=> !irq_o;
  endproperty
  a_irq_needs_gie: assert property (p_irq_needs_gie) // RQ12
    else $error("irq raised while globally disabled");

  property p_secure_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == cocfg_pkg::ADDR_PROG && st.opt[cocfg_pkg::OPT_SECURE]
    |=> rdata_o == cocfg_pkg::READ_BLOCKED;
  endproperty
  a_secure_read: assert property (p_secure_read) // RQ1
    else $error("protected program read back");

  property p_opt_const;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st.booted |=> $stable(st.opt);
  endproperty
  a_opt_const: assert property (p_opt_const) // RQ16
    else $error("option word changed after boot");

  // drive enable must follow a low request from the port, never a high level
  property p_pa5_low;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    pa5_oe_o |-> !pa5_o && $past(pa5_drive_lo_i) && !$past(pa5_is_input_i);
  endproperty
  a_pa5_low: assert property (p_pa5_low) // RQ14
    else $error("pin5 driven high");

  property p_fast_boot;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !st.booted && st.boot_cnt < cocfg_pkg::BOOT_FAST_CNT |=> !booted_o;
  endproperty
  a_fast_boot: assert property (p_fast_boot) // RQ2
    else $error("boot ended too early");

  property p_tclk;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ta_x2_o |-> ta_fast_o && st.opt[cocfg_pkg::OPT_CLK32];
  endproperty
  a_tclk: assert property (p_tclk) // RQ7
    else $error("doubled clock bad");

  property p_out_pins;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !(pb2_o && pb0_o);
  endproperty
  a_out_pins: assert property (p_out_pins) // RQ9
    else $error("timer output on both pins");

  property p_gate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !st.opt[cocfg_pkg::OPT_GATE] && $past(rst_n_i) && st.booted |-> pwm_en_o;
  endproperty
  a_gate: assert property (p_gate) // RQ6
    else $error("pwm gated with option off");
endmodule

// ### dv/cocfg_top_test.sv
// self-checking bench for the code option configuration block
module cocfg_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                        core_clk_i;
  logic                        rst_n_i;
  logic                        slow_osc_i;
  logic [cocfg_pkg::OPT_W-1:0] opt_word;
  logic [3:0]                  addr;
  logic [7:0]                  wdata;
  logic                        wr;
  logic                        rd;
  logic [7:0]                  prog_data;
  logic [4:0]                  pins;      // {a0, a4, b0, b5, cmp}
  logic                        pa5_pin;
  logic                        pa5_in;
  logic                        pa5_lo;
  logic                        pwm_a;
  logic [7:0]                  rdata;
  logic                        booted, irq, wake, pa5, pa5_oe, ext_rst_n, pwm_en, pb2, pb0;
  logic [1:0]                  ta_res, tb_res;
  logic                        ta_fast, tb_fast, ta_x2, tb_x2;
  logic [3:0]                  slow_cnt;
  logic                        wake_seen;
  int                          mismatches;
  int                          comparisons;

  cocfg_top i_cocfg_top (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slow_osc_i(slow_osc_i),
    .opt_word_i(opt_word), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .prog_data_i(prog_data), .port_a_pin0_i(pins[4]), .port_a_pin4_i(pins[3]),
    .port_a_pin5_i(pa5_pin), .port_b_pin0_i(pins[2]), .port_b_pin5_i(pins[1]),
    .cmp_out_i(pins[0]), .pa5_is_input_i(pa5_in), .pa5_drive_lo_i(pa5_lo),
    .pwm_a_i(pwm_a), .rdata_o(rdata), .booted_o(booted), .irq_o(irq), .wake_o(wake),
    .pa5_o(pa5), .pa5_oe_o(pa5_oe), .ext_reset_n_o(ext_rst_n), .pwm_en_o(pwm_en),
    .pb2_o(pb2), .pb0_o(pb0), .ta_res_o(ta_res), .tb_res_o(tb_res),
    .ta_fast_o(ta_fast), .tb_fast_o(tb_fast), .ta_x2_o(ta_x2), .tb_x2_o(tb_x2));

  // 40 MHz system clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // slow oscillator: one rising edge every 4 system clocks, so boot counts stay short
  always @(posedge core_clk_i) begin
    slow_cnt   <= slow_cnt + 4'h1;
    slow_osc_i <= slow_cnt[1];
  end

  // wake is a one-cycle pulse, so it is latched mid-cycle, where it has settled
  always @(negedge core_clk_i) if (wake === 1'b1) wake_seen <= 1'b1;

  task automatic chk1(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_i);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_i);
    rd   <= 1'b0;
    #1;
    chk8(rdata, exp, what);
  endtask

  // reset with a given option word, then time the boot hold-off in system clocks
  task automatic boot(input logic [cocfg_pkg::OPT_W-1:0] opt, input int lim);
    int n;
    n = 0;
    @(posedge core_clk_i);
    rst_n_i  <= 1'b0;
    opt_word <= opt;
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    while (booted !== 1'b1 && n < 20000) begin
      @(posedge core_clk_i);
      n++;
    end
    chk1(n >= lim * 4 - 8 && n <= lim * 4 + 16, 1'b1, "boot hold-off length");
  endtask

  // one pin event: clear requests, move pins, then judge request bits and irq level
  task automatic ev(input logic [4:0] to, input logic [7:0] req, input logic exp_irq);
    wr_reg(cocfg_pkg::ADDR_IRQ_REQ, 8'h07);
    @(posedge core_clk_i);
    pins <= to;
    repeat (8) @(posedge core_clk_i);
    #1;
    chk1(irq, exp_irq, "irq level");
    rd_chk(cocfg_pkg::ADDR_IRQ_REQ, req, "request bits");
  endtask

  task automatic irq_setup();
    wr_reg(cocfg_pkg::ADDR_IRQ_EN, 8'h07);
    wr_reg(cocfg_pkg::ADDR_IRQ_REQ, 8'h07);
    wr_reg(cocfg_pkg::ADDR_GIE, 8'h01);
    rd_chk(cocfg_pkg::ADDR_IRQ_EN, 8'h07, "enable bits");
  endtask

  // option word readback, freeze after boot, program readback gating
  task automatic opt_case(input logic [7:0] exp_opt, input logic [7:0] exp_prog);
    rd_chk(cocfg_pkg::ADDR_OPTIONS, exp_opt, "options");
    rd_chk(cocfg_pkg::ADDR_STATUS, {6'h00, exp_opt[0], 1'b1}, "status");
    wr_reg(cocfg_pkg::ADDR_OPTIONS, 8'hFF);
    opt_word <= ~opt_word;
    rd_chk(cocfg_pkg::ADDR_OPTIONS, exp_opt, "options frozen");
    prog_data <= 8'hA5;
    rd_chk(cocfg_pkg::ADDR_PROG, exp_prog, "program readback");
  endtask

  // timer clock source, resolution, output pin and comparator gating
  task automatic tmr_case(input logic x2, input logic [1:0] res, input logic gate,
                          input logic on_b0);
    wr_reg(cocfg_pkg::ADDR_TA_CTRL, 8'h24);
    wr_reg(cocfg_pkg::ADDR_TB_CTRL, 8'h20);
    wr_reg(cocfg_pkg::ADDR_TA_SCALE, 8'h80);
    wr_reg(cocfg_pkg::ADDR_TB_SCALE, 8'h80);
    pwm_a <= 1'b1;
    pins  <= 5'b00001;
    repeat (8) @(posedge core_clk_i);
    #1;
    chk1(ta_fast, 1'b1, "timer a fast clock");
    chk1(tb_fast, 1'b1, "timer b fast clock");
    chk1(ta_x2, x2, "timer a doubled");
    chk1(tb_x2, x2, "timer b doubled");
    chk8({6'h00, ta_res}, {6'h00, res}, "timer a resolution");
    chk8({6'h00, tb_res}, {6'h00, res}, "timer b resolution");
    chk1(pwm_en, 1'b1, "pwm drive with comparator high");
    chk1(pb2, ~on_b0, "output on pin b2");
    chk1(pb0, on_b0, "output on pin b0");
    pins <= 5'b00000;
    repeat (8) @(posedge core_clk_i);
    #1;
    chk1(pwm_en, ~gate, "pwm drive with comparator low");
    wr_reg(cocfg_pkg::ADDR_TA_CTRL, 8'h34);
    wr_reg(cocfg_pkg::ADDR_TA_SCALE, 8'h00);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk1(ta_fast, 1'b0, "timer a other clock");
    chk8({6'h00, ta_res}, 8'h00, "timer a full resolution");
  endtask

  task automatic wake_case();
    wr_reg(cocfg_pkg::ADDR_IE_A, 8'h00);
    wake_seen <= 1'b0;
    pins      <= 5'b10000;
    repeat (8) @(posedge core_clk_i);
    chk1(wake_seen, 1'b0, "wake with input disabled");
    pins <= 5'b00000;
    wr_reg(cocfg_pkg::ADDR_IE_A, 8'h01);
    wake_seen <= 1'b0;
    pins      <= 5'b10000;
    repeat (8) @(posedge core_clk_i);
    chk1(wake_seen, 1'b1, "wake with input enabled");
    pins <= 5'b00000;
  endtask

  task automatic pa5_case();
    pa5_lo <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk1(pa5_oe, 1'b1, "pin5 drives low");
    chk1(pa5, 1'b0, "pin5 level");
    pa5_lo <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk1(pa5_oe, 1'b0, "pin5 released for high");
    pa5_in <= 1'b1;
    wr_reg(cocfg_pkg::ADDR_CLKMODE, 8'h01);
    repeat (8) @(posedge core_clk_i);
    #1;
    chk1(ext_rst_n, 1'b0, "pin5 as reset input");
    pa5_pin <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    #1;
    chk1(ext_rst_n, 1'b1, "pin5 high releases reset");
    pa5_pin <= 1'b0;
    wr_reg(cocfg_pkg::ADDR_CLKMODE, 8'h00);
    repeat (8) @(posedge core_clk_i);
    #1;
    chk1(ext_rst_n, 1'b1, "pin5 reset function off");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a hang is cut off well past the slow boot plus all other traffic
  initial begin
    #(25ns * 60000);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    {rst_n_i, wr, rd, pa5_pin, pa5_in, pa5_lo, pwm_a} = '0;
    {addr, wdata, prog_data, pins, slow_cnt, slow_osc_i, wake_seen} = '0;
    opt_word = '0;
    mismatches = 0;
    comparisons = 0;
    // fast boot, pin a0 and pin b0 sources, all comparator edges, no gating
    boot(10'h002, cocfg_pkg::BOOT_FAST_CYC);
    opt_case(8'h02, 8'hA5);
    irq_setup();
    ev(5'b10000, 8'h01, 1'b1);
    ev(5'b00010, 8'h00, 1'b0);
    ev(5'b00110, 8'h02, 1'b1);
    ev(5'b01110, 8'h00, 1'b0);
    ev(5'b01111, 8'h04, 1'b1);
    ev(5'b01110, 8'h04, 1'b1);
    ev(5'b00000, 8'h00, 1'b0);
    wr_reg(cocfg_pkg::ADDR_GIE, 8'h00);
    ev(5'b10000, 8'h01, 1'b0);
    tmr_case(1'b0, 2'h1, 1'b0, 1'b0);
    wake_case();
    pa5_case();
    // slow boot, secure, alternate pins, falling edge only, gating, doubled, 7 bit, pin b0
    boot(10'h3ED, cocfg_pkg::BOOT_SLOW_CYC);
    opt_case(8'hED, cocfg_pkg::READ_BLOCKED);
    irq_setup();
    ev(5'b00010, 8'h01, 1'b1);
    ev(5'b10000, 8'h00, 1'b0);
    ev(5'b11000, 8'h02, 1'b1);
    ev(5'b11100, 8'h00, 1'b0);
    ev(5'b11101, 8'h00, 1'b0);
    ev(5'b11100, 8'h04, 1'b1);
    tmr_case(1'b1, 2'h2, 1'b1, 1'b1);
    // fast boot again, comparator on rising edges only
    boot(10'h012, cocfg_pkg::BOOT_FAST_CYC);
    irq_setup();
    ev(5'b00001, 8'h04, 1'b1);
    ev(5'b00000, 8'h00, 1'b0);
    end_sim();
  end
endmodule
